// ---- rmec_checker.sv ----
// Overview of operation
// - RT-to-RT first command must be receive
// - Second command transmit and not broadcast
// - Check sender status sync, address, flags
// - First data sync within 57 us
// - Loop own transmissions back and compare
// - Mismatch, coding or parity error fails
// - Late backend response is a failure
// - Any failure aborts the transfer
// - Set error flag, withhold status word
// - Pulse message-failure interrupt
module rmec_checker (
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	input  wire logic        RT2RT_CMD1_VALID,
	input  wire logic [15:0] RT2RT_CMD1,
	input  wire logic        RT2RT_CMD2_VALID,
	input  wire logic [15:0] RT2RT_CMD2,
	input  wire logic        CMD_PARITY_DONE,
	input  wire logic [4:0]  OWN_ADDR,
	input  wire logic        STATUS_VALID,
	input  wire logic [15:0] STATUS_WORD_IN,
	input  wire logic        STATUS_SYNC_OK,
	input  wire logic        DATA_SYNC,
	input  wire logic        TX_VALID,
	input  wire logic [15:0] TX_WORD,
	input  wire logic        RX_VALID,
	input  wire logic [15:0] RX_WORD,
	input  wire logic        RX_CODE_ERR,
	input  wire logic        RX_PAR_ERR,
	input  wire logic        BE_REQ,
	input  wire logic        BE_ACK,
	input  wire logic        MSG_END,
	input  wire logic        SW_SEND_REQ,
	output logic             ABORT,
	output logic             MESSAGE_ERROR_FLAG,
	output logic             SW_SEND,
	output logic             MSG_FAIL_IRQ,
	output logic [2:0]       FAIL_CAUSE
);
	////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		IDLE, WAIT_CMD2, WAIT_STATUS, WAIT_DATA, IN_DATA
	} rmec_state_e;

	localparam logic [rmec_pkg::FDW_CNT_W-1:0] FDW_LIM =
		rmec_pkg::FDW_CNT_W'(rmec_pkg::FDW_LIMIT_CYC);
	localparam logic [rmec_pkg::BE_CNT_W-1:0] BE_LIM =
		rmec_pkg::BE_CNT_W'(rmec_pkg::BE_LIMIT_CYC);

	function automatic logic is_tx(input logic [15:0] w);
		return w[rmec_pkg::CMD_TR_BIT];
	endfunction

	function automatic logic [4:0] rta(input logic [15:0] w);
		return w[rmec_pkg::CMD_RTA_HI:rmec_pkg::CMD_RTA_LO];
	endfunction

	rmec_state_e                     state_q, state_d;
	logic [rmec_pkg::FDW_CNT_W-1:0]  fdw_cnt_q;
	logic                            fdw_run_q;
	logic [rmec_pkg::BE_CNT_W-1:0]   be_cnt_q;
	logic                            be_run_q;
	logic [4:0]                      tx_addr_q;
	logic                            abort_q;
	logic                            message_error_flag_q;
	logic                            sw_send_q;
	logic                            irq_q;
	logic [2:0]                      cause_q, cause_d;
	logic                            failed_q;
	logic                            fail;

	////////////////////////////////////////////////////////////////////
	rmec_loop_if lb ();
	assign lb.tx_valid    = TX_VALID;
	assign lb.tx_word     = TX_WORD;
	assign lb.rx_valid    = RX_VALID;
	assign lb.rx_word     = RX_WORD;
	assign lb.rx_code_err = RX_CODE_ERR;
	assign lb.rx_par_err  = RX_PAR_ERR;

	rmec_loopback u_loop (
		.clock (CLOCK),
		.reset (RESET),
		.lb    (lb)
	);

	////////////////////////////////////////////////////////////////////
	wire cmd1_bad   = RT2RT_CMD1_VALID && is_tx(RT2RT_CMD1);
	wire cmd2_bad   = RT2RT_CMD2_VALID &&
		(!is_tx(RT2RT_CMD2) || rta(RT2RT_CMD2) == rmec_pkg::BCAST_ADDR);
	wire sw_addr_ok = STATUS_WORD_IN[rmec_pkg::SW_RTA_HI:rmec_pkg::SW_RTA_LO]
		== tx_addr_q;
	wire sw_bad     = STATUS_VALID && (!STATUS_SYNC_OK || !sw_addr_ok ||
		STATUS_WORD_IN[rmec_pkg::SW_MESSAGE_ERROR_FLAG_BIT] ||
		STATUS_WORD_IN[rmec_pkg::SW_BUSY_BIT]);
	wire fdw_late   = fdw_run_q && !DATA_SYNC && fdw_cnt_q >= FDW_LIM;
	wire be_late    = be_run_q && !BE_ACK && be_cnt_q >= BE_LIM;
	wire loop_bad   = lb.mismatch;

	// Fixed priority picks the reported cause if several coincide
	always_comb begin
		cause_d = rmec_pkg::CAUSE_NONE;
		if (state_q == WAIT_CMD2 && cmd2_bad)
			cause_d = rmec_pkg::CAUSE_CMD2;
		else if (state_q == IDLE && cmd1_bad)
			cause_d = rmec_pkg::CAUSE_CMD1;
		else if (state_q == WAIT_STATUS && sw_bad)
			cause_d = rmec_pkg::CAUSE_STATUS;
		else if (fdw_late)
			cause_d = rmec_pkg::CAUSE_TIMEOUT;
		else if (loop_bad)
			cause_d = rmec_pkg::CAUSE_LOOP;
		else if (be_late)
			cause_d = rmec_pkg::CAUSE_BACKEND;
	end

	assign fail = cause_d != rmec_pkg::CAUSE_NONE;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		if (fail || MSG_END) begin
			state_d = IDLE;
		end else begin
			unique case (state_q)
				IDLE:        if (RT2RT_CMD1_VALID) state_d = WAIT_CMD2;
				WAIT_CMD2:   if (RT2RT_CMD2_VALID) state_d = WAIT_STATUS;
				WAIT_STATUS: if (STATUS_VALID) state_d = WAIT_DATA;
				WAIT_DATA:   if (DATA_SYNC) state_d = IN_DATA;
				IN_DATA:     state_d = IN_DATA;
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET)
			state_q <= IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET)
			tx_addr_q <= 5'h00;
		else if (RT2RT_CMD2_VALID)
			tx_addr_q <= rta(RT2RT_CMD2);
	end

	// Timer starts at command parity, only inside an RT-to-RT receive
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			fdw_run_q <= 1'b0;
			fdw_cnt_q <= '0;
		end else if (fail || DATA_SYNC || MSG_END) begin
			fdw_run_q <= 1'b0;
			fdw_cnt_q <= '0;
		end else if (CMD_PARITY_DONE && state_q == WAIT_CMD2) begin
			fdw_run_q <= 1'b1;
			fdw_cnt_q <= '0;
		end else if (fdw_run_q) begin
			fdw_cnt_q <= fdw_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			be_run_q <= 1'b0;
			be_cnt_q <= '0;
		end else if (BE_ACK || fail) begin
			be_run_q <= 1'b0;
			be_cnt_q <= '0;
		end else if (BE_REQ && !be_run_q) begin
			be_run_q <= 1'b1;
			be_cnt_q <= '0;
		end else if (be_run_q) begin
			be_cnt_q <= be_cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Failed message keeps status withheld until MSG_END; the error flag stays set until reset
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			failed_q <= 1'b0;
			message_error_flag_q <= 1'b0;
		end else if (fail) begin
			failed_q <= 1'b1;
			message_error_flag_q <= 1'b1;
		end else if (MSG_END) begin
			failed_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			abort_q   <= 1'b0;
			irq_q     <= 1'b0;
			sw_send_q <= 1'b0;
			cause_q   <= rmec_pkg::CAUSE_NONE;
		end else begin
			abort_q   <= fail;
			irq_q     <= fail;
			sw_send_q <= SW_SEND_REQ && !failed_q && !fail;
			if (fail)
				cause_q <= cause_d;
		end
	end

	assign ABORT              = abort_q;
	assign MESSAGE_ERROR_FLAG = message_error_flag_q;
	assign SW_SEND            = sw_send_q;
	assign MSG_FAIL_IRQ       = irq_q;
	assign FAIL_CAUSE         = cause_q;
endmodule

// ---- rmec_checker_asserts.sv ----
module rmec_checker_asserts (
	input wire logic        CLOCK,
	input wire logic        RESET,
	input wire logic        RT2RT_CMD1_VALID,
	input wire logic [15:0] RT2RT_CMD1,
	input wire logic        CMD_PARITY_DONE,
	input wire logic        STATUS_VALID,
	input wire logic [15:0] STATUS_WORD_IN,
	input wire logic        STATUS_SYNC_OK,
	input wire logic        DATA_SYNC,
	input wire logic        RX_VALID,
	input wire logic        RX_CODE_ERR,
	input wire logic        RX_PAR_ERR,
	input wire logic        BE_REQ,
	input wire logic        BE_ACK,
	input wire logic        ABORT,
	input wire logic        MESSAGE_ERROR_FLAG,
	input wire logic        SW_SEND,
	input wire logic        MSG_FAIL_IRQ,
	input wire logic [2:0]  FAIL_CAUSE
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIM = rmec_pkg::FDW_LIMIT_CYC;
	logic        arm_q;
	int unsigned age_q;
	// Shadow timer, so both early and late timeouts are caught
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			arm_q <= 1'b0;
			age_q <= 0;
		end else begin
			arm_q <= (arm_q | CMD_PARITY_DONE) & ~DATA_SYNC & ~ABORT;
			age_q <= arm_q ? age_q + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (RESET);
	cmd1_rx_a:
		assert property (RT2RT_CMD1_VALID && RT2RT_CMD1[10]
			|=> ABORT && FAIL_CAUSE == 3'h1) else $error("cmd1 kept");
	status_chk_a:
		assert property (STATUS_VALID && (!STATUS_SYNC_OK || STATUS_WORD_IN[10]
			|| STATUS_WORD_IN[3]) |=> ABORT && FAIL_CAUSE == 3'h3) else $error("st");
	fdw_early_a:
		assert property (ABORT && FAIL_CAUSE == 3'h4 |-> age_q >= LIM - 4)
			else $error("timeout early");
	fdw_late_a:
		assert property (age_q <= LIM + 4) else $error("timeout late");
	loop_err_a:
		assert property (RX_VALID && (RX_CODE_ERR || RX_PAR_ERR)
			|=> ##1 ABORT && FAIL_CAUSE == 3'h5) else $error("loop err kept");
	backend_a:
		assert property (BE_REQ && !BE_ACK |-> ##[1:80] (BE_ACK || ABORT))
			else $error("backend hang");
	fail_irq_a:
		assert property (ABORT |-> MSG_FAIL_IRQ && MESSAGE_ERROR_FLAG)
			else $error("no irq");
	flag_hold_a:
		assert property (MESSAGE_ERROR_FLAG |=> MESSAGE_ERROR_FLAG)
			else $error("flag lost");
	sw_hold_a:
		assert property (ABORT |=> !SW_SEND) else $error("status sent");
	cover property (ABORT && FAIL_CAUSE == 3'h4);
	cover property (SW_SEND);
	cover property (BE_ACK);
endmodule
bind rmec_checker rmec_checker_asserts u_rmec_checker_asserts (.*);

// ---- rmec_far_end.sv ----
module rmec_far_end (
	input  wire logic        clock,
	input  wire logic        tx_valid,
	input  wire logic [15:0] tx_word,
	input  wire logic [1:0]  spoil,
	input  wire logic        be_req,
	input  wire logic [7:0]  be_dly,
	output logic             rx_valid,
	output logic [15:0]      rx_word,
	output logic             rx_code_err,
	output logic             rx_par_err,
	output logic             be_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] be_q = 8'h00;
	initial rx_word = 16'h0000;
	// Idle word toggles each cycle so a stale echo never looks valid
	always @(posedge clock) begin
		rx_valid    <= tx_valid;
		rx_word     <= tx_valid ? tx_word ^ 16'(spoil == 2'h1) : ~rx_word;
		rx_code_err <= tx_valid && spoil == 2'h2;
		rx_par_err  <= tx_valid && spoil == 2'h3;
		be_q        <= be_req ? be_dly : be_q - 8'(be_q != 8'h00);
		be_ack      <= be_q == 8'h01;
	end
endmodule

// ---- rmec_loop_if.sv ----
interface rmec_loop_if;
	logic        tx_valid;
	logic [15:0] tx_word;
	logic        rx_valid;
	logic [15:0] rx_word;
	logic        rx_code_err;
	logic        rx_par_err;
	logic        mismatch;
	modport chk (input tx_valid, tx_word, rx_valid, rx_word, rx_code_err,
		rx_par_err, output mismatch);
	modport src (output tx_valid, tx_word, rx_valid, rx_word, rx_code_err,
		rx_par_err, input mismatch);
endinterface

// ---- rmec_loopback.sv ----
module rmec_loopback (
	input  wire logic  clock,
	input  wire logic  reset,
	rmec_loop_if.chk   lb
);
	logic [15:0] sent_q;
	logic        armed_q;
	logic        bad_q;
	wire         differs = lb.rx_word != sent_q;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sent_q  <= 16'h0000;
			armed_q <= 1'b0;
			bad_q   <= 1'b0;
		end else begin
			// Echo is checked even when the next word launches alongside it
			bad_q <= lb.rx_valid && armed_q &&
				(differs || lb.rx_code_err || lb.rx_par_err);
			if (lb.tx_valid) begin
				sent_q  <= lb.tx_word;
				armed_q <= 1'b1;
			end else if (lb.rx_valid && armed_q) begin
				armed_q <= 1'b0;
			end
		end
	end

	assign lb.mismatch = bad_q;
endmodule

// ---- rmec_pkg.sv ----
package rmec_pkg;
	// Core clock and first-data-word limit
	localparam int CLK_MHZ          = 125;
	localparam int FDW_LIMIT_US     = 57;
	localparam int FDW_LIMIT_CYC    = FDW_LIMIT_US * CLK_MHZ;
	localparam int FDW_CNT_W        = 14;
	// Backend response limit in cycles
	localparam int BE_LIMIT_CYC     = 64;
	localparam int BE_CNT_W         = 8;
	// Command word fields
	localparam int CMD_TR_BIT       = 10;
	localparam int CMD_RTA_HI       = 15;
	localparam int CMD_RTA_LO       = 11;
	localparam logic [4:0] BCAST_ADDR = 5'h1F;
	// Status word fields
	localparam int SW_RTA_HI        = 15;
	localparam int SW_RTA_LO        = 11;
	localparam int SW_MESSAGE_ERROR_FLAG_BIT    = 10;
	localparam int SW_BUSY_BIT      = 3;
	// Failure cause codes
	localparam logic [2:0] CAUSE_NONE    = 3'h0;
	localparam logic [2:0] CAUSE_CMD1    = 3'h1;
	localparam logic [2:0] CAUSE_CMD2    = 3'h2;
	localparam logic [2:0] CAUSE_STATUS  = 3'h3;
	localparam logic [2:0] CAUSE_TIMEOUT = 3'h4;
	localparam logic [2:0] CAUSE_LOOP    = 3'h5;
	localparam logic [2:0] CAUSE_BACKEND = 3'h6;
endpackage

// ---- test_rt_message_error_checker.sv ----
module test_rt_message_error_checker;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLOCK, RESET, RT2RT_CMD1_VALID, RT2RT_CMD2_VALID, DATA_SYNC;
	logic        CMD_PARITY_DONE, STATUS_VALID, STATUS_SYNC_OK, TX_VALID;
	logic        RX_VALID, RX_CODE_ERR, RX_PAR_ERR, BE_REQ, BE_ACK, MSG_END;
	logic        SW_SEND_REQ, ABORT, MESSAGE_ERROR_FLAG, SW_SEND, MSG_FAIL_IRQ;
	logic [15:0] RT2RT_CMD1, RT2RT_CMD2, STATUS_WORD_IN, TX_WORD, RX_WORD;
	logic [4:0]  OWN_ADDR;
	logic [2:0]  FAIL_CAUSE;
	logic [1:0]  spoil;
	logic [7:0]  dly;
	int          fails, checks;
	rmec_checker u_rmec_checker (.*);
	rmec_far_end u_rmec_far_end (.clock(CLOCK), .tx_valid(TX_VALID),
		.tx_word(TX_WORD), .spoil(spoil), .be_req(BE_REQ), .be_dly(dly),
		.rx_valid(RX_VALID), .rx_word(RX_WORD), .rx_code_err(RX_CODE_ERR),
		.rx_par_err(RX_PAR_ERR), .be_ack(BE_ACK));
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	initial begin
		#400000;
		fails++;
		results;
	end
	////////////////////////////////////////////////////////////////////
	task automatic results;
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic tick;
		@(posedge CLOCK);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick;
		s = 1'b0;
	endtask
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	// Sender status; bad 1..4 spoils sync, address, error flag, busy
	function automatic logic [15:0] sw_of(logic [15:0] b, int bad);
		return {b[15:11] ^ 5'(bad == 2), bad == 3, 6'h00, bad == 4, 3'h0};
	endfunction
	function automatic logic [2:0] cause_of(int k);
		return k == 1 ? 3'h1 : k < 4 ? 3'h2 : k < 8 ? 3'h3 : k == 8 ? 3'h4
			: k < 12 ? 3'h5 : 3'h6;
	endfunction
	task automatic cmds(logic [15:0] a, logic [15:0] b);
		RT2RT_CMD1 = a;
		RT2RT_CMD2 = b;
		pulse(RT2RT_CMD1_VALID);
		if (ABORT === 1'b1) return;
		CMD_PARITY_DONE = 1'b1;
		pulse(RT2RT_CMD2_VALID);
		CMD_PARITY_DONE = 1'b0;
	endtask
	task automatic fail_wait(logic [2:0] c);
		int n;
		n = 0;
		while (ABORT !== 1'b1 && n < 8000) begin
			tick;
			n++;
		end
		chk({ABORT, MSG_FAIL_IRQ}, 2'h3);
		chk(FAIL_CAUSE, c);
		pulse(SW_SEND_REQ);
		chk({SW_SEND, MESSAGE_ERROR_FLAG}, 2'h1);
		pulse(MSG_END);
		pulse(SW_SEND_REQ);
		chk(SW_SEND, 1'b1);
	endtask
	initial begin
		logic [15:0] a, b;
		{RT2RT_CMD1_VALID, RT2RT_CMD2_VALID, CMD_PARITY_DONE, STATUS_VALID,
			STATUS_SYNC_OK, DATA_SYNC, TX_VALID, BE_REQ, MSG_END, SW_SEND_REQ,
			spoil, dly, OWN_ADDR, RT2RT_CMD1, RT2RT_CMD2, STATUS_WORD_IN,
			TX_WORD} = '0;
		RESET = 1'b1;
		void'($urandom(68423));
		repeat (16) tick;
		RESET = 1'b0;
		// Case 0 is clean and must come first: the error flag is sticky
		for (int k = 0; k < 13; k++) begin
			a = $urandom;
			b = $urandom;
			a[10] = k == 1;
			b[10] = k != 2;
			b[15:11] = k == 3 ? 5'h1F : b[15:11] & 5'h1E;
			TX_WORD = a;
			spoil = 2'(k - 8);
			dly = k == 12 ? 8'h00 : 8'h0A;
			if (k < 9) begin
				cmds(a, b);
				STATUS_WORD_IN = sw_of(b, k - 3);
				STATUS_SYNC_OK = k != 4;
				if (ABORT !== 1'b1) pulse(STATUS_VALID);
			end else if (k < 12) pulse(TX_VALID);
			else pulse(BE_REQ);
			if (k > 0) fail_wait(cause_of(k));
			else begin
				pulse(DATA_SYNC);
				pulse(TX_VALID);
				pulse(BE_REQ);
				pulse(SW_SEND_REQ);
				chk(SW_SEND, 1'b1);
				repeat (80) tick;
				chk(MESSAGE_ERROR_FLAG, 1'b0);
				pulse(MSG_END);
			end
		end
		results;
	end
endmodule
